// ==== design/bts_sequencer.sv ====
// Brake check sequencer with its Avalon-MM register slave
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "bts_defs.svh"
module bts_sequencer
   import bts_pkg::*;
#(
   parameter int MON_CYCLE_CYCLES = `BTS_MON_CYCLE_CYC,
   parameter int TIMEOUT_TICKS    = `BTS_EXT_TIMEOUT_TICKS
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic [2:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic [4:0]  brake_check_control_inputs_i,
   input  wire logic [15:0] fieldbus_safety_ctrl_word_b3_i,
   input  wire logic [15:0] fieldbus_safety_ctrl_word_b1_i,
   input  wire logic        test_stop_request_input_i,
   input  wire logic        pulses_enabled_i,
   input  wire logic        ext_brake_closed_i,
   input  wire logic [15:0] speed_actual_i,
   input  wire logic [15:0] speed_setpoint_i,
   input  wire logic [15:0] position_deviation_i,
   input  wire logic        fail_safe_ack_i,
   output logic      [1:0]  brake_check_control_feedback_o,
   output logic      [15:0] brake_check_status_word_o,
   output logic             int_brake_open_o,
   output logic      [15:0] speed_setpoint_o,
   output logic      [15:0] test_torque_o,
   output logic             test_torque_neg_o,
   output logic             load_measure_o,
   output logic             forced_check_start_o
);
   // ****************************************
   // Register slave
   // ****************************************
   logic [31:0] ctrl_reg, ctrl_next, moncyc_reg, moncyc_next, ramp_reg, ramp_next;
   logic [31:0] torq_reg, torq_next, dur_reg, dur_next, maxspd_reg, maxspd_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        wait_reg, wait_next;
   bts_state_t  state_reg, state_next;
   logic [15:0] status_reg, status_next;

   always_comb begin
      ctrl_next   = ctrl_reg;
      moncyc_next = moncyc_reg;
      ramp_next   = ramp_reg;
      torq_next   = torq_reg;
      dur_next    = dur_reg;
      maxspd_next = maxspd_reg;
      rdata_next  = rdata_reg;
      // One wait cycle per access keeps read data registered
      wait_next   = !((avs_read_i || avs_write_i) && wait_reg);
      if (avs_write_i && !wait_reg) begin
         case (avs_address_i)
            `BTS_REG_CTRL:   ctrl_next   = {26'h0, avs_writedata_i[5:0]};
            `BTS_REG_MONCYC: moncyc_next = avs_writedata_i;
            `BTS_REG_RAMP:   ramp_next   = avs_writedata_i;
            `BTS_REG_TORQ:   torq_next   = avs_writedata_i;
            `BTS_REG_DUR:    dur_next    = avs_writedata_i;
            `BTS_REG_MAXSPD: maxspd_next = {16'h0, avs_writedata_i[15:0]};
            default:         ctrl_next   = ctrl_reg;
         endcase
      end
      if (avs_read_i && wait_reg) begin
         case (avs_address_i)
            `BTS_REG_CTRL:   rdata_next = ctrl_reg;
            `BTS_REG_MONCYC: rdata_next = moncyc_reg;
            `BTS_REG_RAMP:   rdata_next = ramp_reg;
            `BTS_REG_TORQ:   rdata_next = torq_reg;
            `BTS_REG_DUR:    rdata_next = dur_reg;
            `BTS_REG_MAXSPD: rdata_next = maxspd_reg;
            `BTS_REG_STATUS: rdata_next = {13'h0, state_reg, status_reg};
            default:         rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ctrl_reg   <= `BTS_CTRL_RST;
         moncyc_reg <= 32'(MON_CYCLE_CYCLES);
         ramp_reg   <= `BTS_RAMP_RST;
         torq_reg   <= `BTS_TORQ_RST;
         dur_reg    <= `BTS_DUR_RST;
         maxspd_reg <= `BTS_MAXSPD_RST;
         rdata_reg  <= 32'h0000_0000;
         wait_reg   <= 1'b1;
      end else begin
         ctrl_reg   <= ctrl_next;
         moncyc_reg <= moncyc_next;
         ramp_reg   <= ramp_next;
         torq_reg   <= torq_next;
         dur_reg    <= dur_next;
         maxspd_reg <= maxspd_next;
         rdata_reg  <= rdata_next;
         wait_reg   <= wait_next;
      end
   end

   assign avs_readdata_o    = rdata_reg;
   assign avs_waitrequest_o = wait_reg;

   // ****************************************
   // Monitoring tick and phase timer
   // ****************************************
   logic        tick;
   logic        phase_clear;
   logic [15:0] phase_limit;
   logic [15:0] elapsed;
   logic        phase_done;

   bts_counter #(.W(32)) u_prescaler (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .clear_i    (tick),
      .en_i       (1'b1),
      .limit_i    (moncyc_reg - 32'h0000_0001),
      .count_o    (),
      .done_o     (tick)
   );

   bts_counter #(.W(16)) u_phase (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .clear_i    (phase_clear),
      .en_i       (tick),
      .limit_i    (phase_limit),
      .count_o    (elapsed),
      .done_o     (phase_done)
   );

   // ****************************************
   // Sequencer
   // ****************************************
   bts_src_t    src;
   logic        sel_lvl, start_lvl, ts_lvl, sel_prev_reg, start_prev_reg, ts_prev_reg;
   logic        sel_rise, sel_fall, start_rise, start_fall, ts_rise;
   logic [1:0]  fb_reg, fb_next;
   logic        brake_reg, brake_next, neg_reg, neg_next, seq_reg, seq_next;
   logic        auto_reg, auto_next, fault_reg, fault_next, alarm_reg, alarm_next;
   logic        passed_reg, passed_next, load_reg, load_next, fc_reg, fc_next;
   logic        int_open_reg, int_open_next;
   logic [15:0] torque_reg, torque_next, spd_out_reg, spd_out_next, torq_tgt;
   logic        tested_ext, in_test, speed_sel_ok, speed_run_ok, abort;
   logic [31:0] torque_x_ramp, tgt_x_elapsed, tgt_x_left;
   logic [22:0] spd_sel_scaled;
   logic [19:0] spd_run_scaled;

   always_comb begin
      src = bts_src_t'(ctrl_reg[`BTS_CTRL_SRC_HI:`BTS_CTRL_SRC_LO]);
      case (src)
         BTS_SRC_DISCRETE: begin
            sel_lvl   = brake_check_control_inputs_i[`BTS_CI_SEL];
            start_lvl = brake_check_control_inputs_i[`BTS_CI_START];
         end
         BTS_SRC_FIELDBUS: begin
            sel_lvl   = fieldbus_safety_ctrl_word_b3_i[`BTS_CI_SEL];
            start_lvl = fieldbus_safety_ctrl_word_b3_i[`BTS_CI_START];
         end
         default: begin
            sel_lvl   = 1'b0;
            start_lvl = 1'b0;
         end
      endcase
      ts_lvl     = (src == BTS_SRC_TESTSTOP) &&
                   (test_stop_request_input_i || fieldbus_safety_ctrl_word_b1_i[`BTS_TS_BIT]);
      sel_rise   = sel_lvl && !sel_prev_reg;
      sel_fall   = !sel_lvl && sel_prev_reg;
      start_rise = start_lvl && !start_prev_reg;
      start_fall = !start_lvl && start_prev_reg;
      ts_rise    = ts_lvl && !ts_prev_reg;
   end

   always_comb begin
      tested_ext     = brake_reg ? ctrl_reg[`BTS_CTRL_EXT2] : ctrl_reg[`BTS_CTRL_EXT1];
      in_test        = (state_reg == BTS_CLOSING) || (state_reg == BTS_RAMP_UP) ||
                       (state_reg == BTS_HOLD) || (state_reg == BTS_RAMP_DOWN);
      spd_sel_scaled = 23'(speed_actual_i) * 23'(`BTS_SEL_PCT);
      spd_run_scaled = 20'(speed_actual_i) * 20'(`BTS_RUN_PCT);
      speed_sel_ok   = spd_sel_scaled <= 23'(maxspd_reg[15:0]);
      speed_run_ok   = spd_run_scaled <= 20'(maxspd_reg[15:0]);
      torq_tgt       = seq_reg ? torq_reg[31:16] : torq_reg[15:0];
      torque_x_ramp  = 32'(torque_reg) * 32'(ramp_reg[15:0]);
      tgt_x_elapsed  = 32'(torq_tgt) * 32'(elapsed);
      tgt_x_left     = 32'(torq_tgt) * 32'(ramp_reg[15:0] - elapsed);
      case (state_reg)
         BTS_RAMP_UP, BTS_RAMP_DOWN: phase_limit = ramp_reg[15:0];
         BTS_HOLD:                   phase_limit = seq_reg ? dur_reg[31:16] : dur_reg[15:0];
         default:                    phase_limit = 16'(TIMEOUT_TICKS);
      endcase
   end

   always_comb begin
      state_next    = state_reg;
      fb_next       = fb_reg;
      brake_next    = brake_reg;
      neg_next      = neg_reg;
      seq_next      = seq_reg;
      auto_next     = auto_reg;
      fault_next    = fault_reg;
      alarm_next    = alarm_reg;
      passed_next   = passed_reg;
      torque_next   = torque_reg;
      load_next     = 1'b0;
      fc_next       = 1'b0;
      abort         = 1'b0;
      // Faults clear on acknowledge only in idle; alarms clear anytime
      if (fail_safe_ack_i) begin
         alarm_next = 1'b0;
         if (state_reg == BTS_IDLE) begin
            fault_next = 1'b0;
         end
      end
      case (state_reg)
         BTS_IDLE: begin
            if (sel_rise || ts_rise) begin
               if (pulses_enabled_i && speed_sel_ok) begin
                  state_next  = BTS_SEL_OPEN;
                  auto_next   = ts_rise;
                  passed_next = 1'b0;
               end else begin
                  fault_next = 1'b1;
               end
            end
         end
         BTS_SEL_OPEN: begin
            if (pulses_enabled_i && !ext_brake_closed_i &&
                (int_open_reg || !ctrl_reg[`BTS_CTRL_HB_CFG])) begin
               state_next = BTS_READY;
               fb_next[0] = 1'b1;
               load_next  = 1'b1;
            end else if (phase_done) begin
               fault_next = 1'b1;
               abort      = 1'b1;
            end
         end
         BTS_READY: begin
            if (auto_reg) begin
               brake_next = 1'b0;
               seq_next   = 1'b0;
               neg_next   = ctrl_reg[`BTS_CTRL_SIGN];
               fb_next[1] = 1'b1;
               state_next = BTS_CLOSING;
            end else if (start_rise) begin
               brake_next = brake_check_selector(`BTS_CI_BRAKE);
               neg_next   = brake_check_selector(`BTS_CI_SIGN);
               seq_next   = brake_check_selector(`BTS_CI_SEQ);
               fb_next[1] = 1'b1;
               state_next = BTS_CLOSING;
            end
         end
         BTS_CLOSING: begin
            if (!tested_ext || ext_brake_closed_i) begin
               state_next = BTS_RAMP_UP;
            end else if (phase_done) begin
               fault_next = 1'b1;
               state_next = BTS_DONE;
            end
         end
         BTS_RAMP_UP: begin
            if ((torque_reg < torq_tgt) && (torque_x_ramp < tgt_x_elapsed || phase_done)) begin
               torque_next = torque_reg + 16'h0001;
            end else if (phase_done) begin
               state_next = BTS_HOLD;
            end
         end
         BTS_HOLD: begin
            if (position_deviation_i > ramp_reg[31:16]) begin
               fault_next = 1'b1;
               state_next = BTS_RAMP_DOWN;
            end else if (phase_done) begin
               passed_next = 1'b1;
               state_next  = BTS_RAMP_DOWN;
            end
         end
         BTS_RAMP_DOWN: begin
            if ((torque_reg != 16'h0000) && (torque_x_ramp > tgt_x_left || phase_done)) begin
               torque_next = torque_reg - 16'h0001;
            end else if (torque_reg == 16'h0000) begin
               state_next = BTS_DONE;
            end
         end
         default: begin
            torque_next = 16'h0000;
            if (auto_reg) begin
               fc_next = 1'b1;
               abort   = 1'b1;
            end else if (start_fall) begin
               fb_next[1] = 1'b0;
               state_next = BTS_READY;
            end
         end
      endcase
      if (in_test && !auto_reg && start_fall) begin
         alarm_next  = 1'b1;
         torque_next = 16'h0000;
         fb_next[1]  = 1'b0;
         state_next  = BTS_READY;
      end
      if (state_reg != BTS_IDLE && !speed_run_ok) begin
         fault_next = 1'b1;
         abort      = 1'b1;
      end
      if (state_reg != BTS_IDLE && !auto_reg && sel_fall) begin
         abort = 1'b1;
      end
      if (abort) begin
         state_next  = BTS_IDLE;
         fb_next     = 2'b00;
         torque_next = 16'h0000;
         auto_next   = 1'b0;
      end
      phase_clear = state_next != state_reg;
      // Only the brake under test closes, except internal brake 2, which stays open; internal opens with pulses when BTS_CTRL_HB_CFG is set
      int_open_next = ctrl_reg[`BTS_CTRL_HB_CFG] && pulses_enabled_i &&
                      !(in_test && !tested_ext && !brake_reg);
      spd_out_next  = (state_next == BTS_IDLE) ? speed_setpoint_i : 16'h0000;
      status_next   = 16'h0000;
      status_next[`BTS_ST_SEL]       = fb_next[0];
      status_next[`BTS_ST_ACTIVE]    = fb_next[1];
      status_next[`BTS_ST_PASSED]    = passed_next;
      status_next[`BTS_ST_FAULT]     = fault_next;
      status_next[`BTS_ST_ALARM]     = alarm_next;
      status_next[`BTS_ST_RAMP]      = (state_next == BTS_RAMP_UP) || (state_next == BTS_RAMP_DOWN);
      status_next[`BTS_ST_EXT_CLOSE] = tested_ext && (state_next == BTS_CLOSING ||
                                       state_next == BTS_RAMP_UP || state_next == BTS_HOLD ||
                                       state_next == BTS_RAMP_DOWN);
   end

   function automatic logic brake_check_selector(input int bit_idx);
      brake_check_selector = (src == BTS_SRC_DISCRETE) ? brake_check_control_inputs_i[bit_idx]
                                                        : fieldbus_safety_ctrl_word_b3_i[bit_idx];
   endfunction

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg      <= BTS_IDLE;
         sel_prev_reg   <= 1'b0;
         start_prev_reg <= 1'b0;
         ts_prev_reg    <= 1'b0;
         fb_reg         <= 2'b00;
         brake_reg      <= 1'b0;
         neg_reg        <= 1'b0;
         seq_reg        <= 1'b0;
         auto_reg       <= 1'b0;
         fault_reg      <= 1'b0;
         alarm_reg      <= 1'b0;
         passed_reg     <= 1'b0;
         torque_reg     <= 16'h0000;
         load_reg       <= 1'b0;
         fc_reg         <= 1'b0;
         int_open_reg   <= 1'b0;
         spd_out_reg    <= 16'h0000;
         status_reg     <= 16'h0000;
      end else begin
         state_reg      <= state_next;
         sel_prev_reg   <= sel_lvl;
         start_prev_reg <= start_lvl;
         ts_prev_reg    <= ts_lvl;
         fb_reg         <= fb_next;
         brake_reg      <= brake_next;
         neg_reg        <= neg_next;
         seq_reg        <= seq_next;
         auto_reg       <= auto_next;
         fault_reg      <= fault_next;
         alarm_reg      <= alarm_next;
         passed_reg     <= passed_next;
         torque_reg     <= torque_next;
         load_reg       <= load_next;
         fc_reg         <= fc_next;
         int_open_reg   <= int_open_next;
         spd_out_reg    <= spd_out_next;
         status_reg     <= status_next;
      end
   end

   assign brake_check_control_feedback_o = fb_reg;
   assign brake_check_status_word_o      = status_reg;
   assign int_brake_open_o               = int_open_reg;
   assign speed_setpoint_o               = spd_out_reg;
   assign test_torque_o                  = torque_reg;
   assign test_torque_neg_o              = neg_reg;
   assign load_measure_o                 = load_reg;
   assign forced_check_start_o           = fc_reg;
endmodule

// ==== design/bts_defs.svh ====
// Offsets, field positions, reset values and timing counts of the brake check sequencer
`ifndef BTS_DEFS_SVH
`define BTS_DEFS_SVH
// ****************************************
// Register word indices (byte address = 4 * index)
// ****************************************
`define BTS_REG_CTRL      3'h0
`define BTS_REG_MONCYC    3'h1
`define BTS_REG_RAMP      3'h2
`define BTS_REG_TORQ      3'h3
`define BTS_REG_DUR       3'h4
`define BTS_REG_MAXSPD    3'h5
`define BTS_REG_STATUS    3'h6
// ****************************************
// Control register fields
// ****************************************
`define BTS_CTRL_SRC_LO   0
`define BTS_CTRL_SRC_HI   1
`define BTS_CTRL_HB_CFG   2
`define BTS_CTRL_EXT1     3
`define BTS_CTRL_EXT2     4
`define BTS_CTRL_SIGN     5
`define BTS_CTRL_RST      32'h0000_0004
// ****************************************
// Status word fields
// ****************************************
`define BTS_ST_SEL        0
`define BTS_ST_ACTIVE     1
`define BTS_ST_PASSED     2
`define BTS_ST_FAULT      3
`define BTS_ST_ALARM      4
`define BTS_ST_RAMP       5
`define BTS_ST_EXT_CLOSE  6
// ****************************************
// Control input bits
// ****************************************
`define BTS_CI_SEL        0
`define BTS_CI_START      1
`define BTS_CI_BRAKE      2
`define BTS_CI_SIGN       3
`define BTS_CI_SEQ        4
`define BTS_TS_BIT        8
// ****************************************
// Timing
// ****************************************
`define BTS_CLK_HZ        40000000
`define BTS_MON_CYCLE_US  1000
`define BTS_MON_CYCLE_CYC (`BTS_MON_CYCLE_US * (`BTS_CLK_HZ / 1000000))
`define BTS_EXT_TIMEOUT_MS 11000
`define BTS_EXT_TIMEOUT_TICKS ((`BTS_EXT_TIMEOUT_MS * 1000) / `BTS_MON_CYCLE_US)
`define BTS_RAMP_RST      32'h0000_0064
`define BTS_TORQ_RST      32'h0100_0100
`define BTS_DUR_RST       32'h03E8_03E8
`define BTS_MAXSPD_RST    32'h0000_FFFF
`define BTS_SEL_PCT       100
`define BTS_RUN_PCT       10
`endif

// ==== design/bts_pkg.sv ====
// Types shared by the brake check sequencer
package bts_pkg;
   typedef enum logic [2:0] {
      BTS_IDLE      = 3'h0,
      BTS_SEL_OPEN  = 3'h1,
      BTS_READY     = 3'h3,
      BTS_CLOSING   = 3'h2,
      BTS_RAMP_UP   = 3'h6,
      BTS_HOLD      = 3'h7,
      BTS_RAMP_DOWN = 3'h5,
      BTS_DONE      = 3'h4
   } bts_state_t;
   typedef enum logic [1:0] {
      BTS_SRC_FIELDBUS = 2'h0,
      BTS_SRC_DISCRETE = 2'h1,
      BTS_SRC_TESTSTOP = 2'h2
   } bts_src_t;
endpackage

// ==== design/bts_counter.sv ====
// Restartable up counter with a registered reached flag
`timescale 1ns/1ps
module bts_counter #(
   parameter int W = 16
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   input  wire logic         clear_i,
   input  wire logic         en_i,
   input  wire logic [W-1:0] limit_i,
   output logic      [W-1:0] count_o,
   output logic              done_o
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic         done_reg;
   logic         done_next;

   always_comb begin
      count_next = count_reg;
      if (clear_i) begin
         count_next = '0;
      end else if (en_i && (count_reg < limit_i)) begin
         count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
      end
      done_next = !clear_i && (count_next >= limit_i);
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         count_reg <= '0;
         done_reg  <= 1'b0;
      end else begin
         count_reg <= count_next;
         done_reg  <= done_next;
      end
   end

   assign count_o = count_reg;
   assign done_o  = done_reg;
endmodule

// ==== sim/bts_sequencer_asserts.sv ====
// Port checker for the brake check sequencer
`timescale 1ns/1ps
module bts_sequencer_asserts (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic        avs_waitrequest_o,
   input  wire logic        pulses_enabled_i,
   input  wire logic        fail_safe_ack_i,
   input  wire logic [15:0] speed_setpoint_i,
   input  wire logic [1:0]  brake_check_control_feedback_o,
   input  wire logic [15:0] brake_check_status_word_o,
   input  wire logic [15:0] speed_setpoint_o,
   input  wire logic        load_measure_o,
   input  wire logic        forced_check_start_o
);
   logic [1:0]  fb;
   logic [15:0] st;
   assign fb = brake_check_control_feedback_o;
   assign st = brake_check_status_word_o;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   wait_ans_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("bus access not answered");
   wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   sel_pulse_a: assert property ($rose(fb[0]) |-> $past(pulses_enabled_i))
      else $error("selected without pulses");
   meas_at_sel_a: assert property ($rose(fb[0]) |-> ##[0:1] load_measure_o)
      else $error("no load measurement at selection");
   forced_pulse_a: assert property (forced_check_start_o |=> !forced_check_start_o)
      else $error("forced check start not a pulse");
   setpt_back_a: assert property ($fell(fb[0]) |-> ##[1:2]
      speed_setpoint_o == $past(speed_setpoint_i)) else $error("setpoint not restored");
   close_req_a: assert property (st[6] |-> fb[1])
      else $error("close request without start");
   fault_ack_a: assert property ($fell(st[3]) |-> $past(fail_safe_ack_i))
      else $error("fault cleared without acknowledge");
   alarm_cancel_a: assert property ($rose(st[4]) |-> !fb[1])
      else $error("alarm without cancel");
   cover property ($rose(fb[1]));
   cover property ($rose(st[4]));
   cover property (forced_check_start_o);
endmodule
bind bts_sequencer bts_sequencer_asserts bts_sequencer_asserts_inst (.core_clk_i, .rst_i,
   .avs_read_i, .avs_write_i, .avs_waitrequest_o, .pulses_enabled_i, .fail_safe_ack_i,
   .speed_setpoint_i, .brake_check_control_feedback_o, .brake_check_status_word_o,
   .speed_setpoint_o, .load_measure_o, .forced_check_start_o);

// ==== sim/bts_brake_model.sv ====
// External brake model: moves only on request, after a delay
`timescale 1ns/1ps
module bts_brake_model #(
   parameter int DLY = 3
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic close_req_i,
   input  wire logic stall_i,
   output logic      closed_o
);
   int cnt_reg;
   // A stalled brake stays put, so the timeout path is reachable
   always_ff @(posedge clk_i) begin
      if (rst_i || stall_i || close_req_i == closed_o) begin
         cnt_reg <= 0;
         closed_o <= rst_i ? 1'b0 : closed_o;
      end else if (cnt_reg == DLY) begin
         closed_o <= close_req_i;
         cnt_reg <= 0;
      end else begin
         cnt_reg <= cnt_reg + 1;
      end
   end
endmodule

// ==== sim/bts_sequencer_tb_top.sv ====
// Self-checking bench for the brake check sequencer
`timescale 1ns/1ps
`include "bts_defs.svh"
module bts_sequencer_tb_top;
   logic        core_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, stall;
   logic [2:0]  avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o;
   logic [4:0]  brake_check_control_inputs_i;
   logic [15:0] fieldbus_safety_ctrl_word_b3_i, fieldbus_safety_ctrl_word_b1_i;
   logic        test_stop_request_input_i, pulses_enabled_i, ext_brake_closed_i;
   logic [15:0] speed_actual_i, speed_setpoint_i, position_deviation_i;
   logic        fail_safe_ack_i, int_brake_open_o, test_torque_neg_o, load_measure_o;
   logic        forced_check_start_o;
   logic [1:0]  brake_check_control_feedback_o;
   logic [15:0] brake_check_status_word_o, speed_setpoint_o, test_torque_o;
   int          mismatches, tests_run;
   bts_sequencer #(.MON_CYCLE_CYCLES(8), .TIMEOUT_TICKS(5)) bts_sequencer_inst (
      .core_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
      .avs_readdata_o, .avs_waitrequest_o, .brake_check_control_inputs_i,
      .fieldbus_safety_ctrl_word_b3_i, .fieldbus_safety_ctrl_word_b1_i,
      .test_stop_request_input_i, .pulses_enabled_i, .ext_brake_closed_i, .speed_actual_i,
      .speed_setpoint_i, .position_deviation_i, .fail_safe_ack_i,
      .brake_check_control_feedback_o, .brake_check_status_word_o, .int_brake_open_o,
      .speed_setpoint_o, .test_torque_o, .test_torque_neg_o, .load_measure_o,
      .forced_check_start_o);
   bts_brake_model bts_brake_model_inst (.clk_i(core_clk_i), .rst_i, .stall_i(stall),
      .close_req_i(brake_check_status_word_o[6]), .closed_o(ext_brake_closed_i));
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   task automatic test_done;
      $display("Checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
      avs_writedata_i <= avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic ctl(input logic fbus, input logic [4:0] v);
      if (fbus)
         fieldbus_safety_ctrl_word_b3_i <= {11'h000, v};
      else
         brake_check_control_inputs_i <= v;
      @(posedge core_clk_i);
   endtask
   task automatic wait_st(input int i, input logic v);
      int n;
      n = 0;
      while (brake_check_status_word_o[i] !== v && n < 400) begin
         @(posedge core_clk_i);
         n++;
      end
      chk(brake_check_status_word_o[i], v);
   endtask
   task automatic ack;
      fail_safe_ack_i <= 1'b1;
      @(posedge core_clk_i);
      fail_safe_ack_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      bus(1'b0, `BTS_REG_CTRL, 32'h0);
      chk(avs_writedata_i, `BTS_CTRL_RST);
      bus(1'b1, 3'h7, 32'h0000_00FF);
      bus(1'b0, 3'h7, 32'h0);
      chk(avs_writedata_i, 32'h0);
      bus(1'b1, `BTS_REG_RAMP, 32'h0010_0002);
      bus(1'b1, `BTS_REG_DUR, 32'h0003_0003);
   endtask
   task automatic t_ext_run;
      bus(1'b1, `BTS_REG_CTRL, 32'h0000_000D);
      ctl(1'b0, 5'h01);
      wait_st(0, 1'b1);
      chk(speed_setpoint_o, 32'h0);
      ctl(1'b0, 5'h03);
      wait_st(6, 1'b1);
      wait_st(2, 1'b1);
      chk(test_torque_o, 32'h0000_0100);
      wait_st(6, 1'b0);
      ctl(1'b0, 5'h01);
      repeat (8) @(posedge core_clk_i);
      chk(brake_check_control_feedback_o, 32'h1);
      ctl(1'b0, 5'h00);
      wait_st(0, 1'b0);
      repeat (2) @(posedge core_clk_i);
      chk(speed_setpoint_o, 32'h1234);
   endtask
   task automatic t_cancel;
      bus(1'b1, `BTS_REG_CTRL, 32'h0000_0004);
      ctl(1'b1, 5'h01);
      wait_st(0, 1'b1);
      ctl(1'b1, 5'h0B);
      wait_st(5, 1'b1);
      chk(test_torque_neg_o, 32'h1);
      ctl(1'b1, 5'h09);
      wait_st(4, 1'b1);
      ack;
      wait_st(4, 1'b0);
      repeat (8) @(posedge core_clk_i);
      ctl(1'b1, 5'h00);
      wait_st(0, 1'b0);
   endtask
   task automatic t_timeout;
      int n;
      n = 0;
      bus(1'b1, `BTS_REG_CTRL, 32'h0000_000D);
      stall <= 1'b1;
      ctl(1'b0, 5'h01);
      wait_st(0, 1'b1);
      ctl(1'b0, 5'h03);
      wait_st(6, 1'b1);
      while (brake_check_status_word_o[3] !== 1'b1 && n < 400) begin
         @(posedge core_clk_i);
         n++;
      end
      chk(n inside {[32:56]}, 32'h1);
      ctl(1'b0, 5'h01);
      repeat (8) @(posedge core_clk_i);
      ctl(1'b0, 5'h00);
      stall <= 1'b0;
      wait_st(0, 1'b0);
      ack;
      wait_st(3, 1'b0);
   endtask
   task automatic t_test_stop;
      int n;
      n = 0;
      bus(1'b1, `BTS_REG_CTRL, 32'h0000_0006);
      test_stop_request_input_i <= 1'b1;
      wait_st(5, 1'b1);
      chk(int_brake_open_o, 32'h0);
      chk(test_torque_neg_o, 32'h0);
      while (forced_check_start_o !== 1'b1 && n < 600) begin
         @(posedge core_clk_i);
         n++;
      end
      chk(forced_check_start_o, 32'h1);
      test_stop_request_input_i <= 1'b0;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk_i);
      mismatches++;
      test_done;
   end
   initial begin
      {avs_read_i, avs_write_i, test_stop_request_input_i, fail_safe_ack_i, stall} = '0;
      {avs_address_i, avs_writedata_i, brake_check_control_inputs_i} = '0;
      {fieldbus_safety_ctrl_word_b3_i, fieldbus_safety_ctrl_word_b1_i} = '0;
      {speed_actual_i, position_deviation_i} = '0;
      pulses_enabled_i = 1'b1;
      speed_setpoint_i = 16'h1234;
      rst_i = 1'b1;
      repeat (16) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      t_regs;
      t_ext_run;
      t_cancel;
      t_timeout;
      t_test_stop;
      test_done;
   end
endmodule
